// >>> char_mode_serial_port.sv
// Purpose: character-mode asynchronous serial port with APB registers
// Assumes: one 100 MHz clock, asynchronous active-low reset, 16x oversampling
// Notes: receive buffer of 1024 characters, transmit one character at a time
//
// Overview of operation
// - enabled end character received finishes the pending reception at once
// - two end-character slots, each enabled on its own, first match ends
// - programmable end character masked to 7 bits in 7-bit mode
// - per-slot include bit keeps or drops the matched end character
// - silence and end-character termination exclude each other on write
// - no termination at all is a legal setting
// - silence termination ends reception after programmed quiet milliseconds
// - silence never shorter than 12 or 15 bit times by character length
// - silence setting held between 1 ms and 10000 ms
// - RS485 forces data-only signals
// - RS232 offers data-only or RTS/CTS terminal handshake set
// - CTS wait limit acts only with RS232 plus handshake set
// - in handshake mode transmission waits for CTS active
// - CTS wait beyond limit, up to 10 s, drops the character unsent
// - wait limit zero, the reset value, waits without bound
// - RTS drives partner CTS; with handshake a character starts only while own CTS asserted
// - eight baud rates from 300 to 38400 bits per second
// - data width 7 or 8 bits
// - one or two stop bits
// - parity even, odd or none; none sends and expects no parity bit
// - reset gives no termination, RS232, data only, 9600, 8 bits, 1 stop, odd
// - 1024-entry circular receive buffer overwrites oldest, entries cleared on read
// - every transmitted character echoed into the receive buffer
// - clear request empties buffer then reception goes on
`timescale 1ns/1ns
module char_mode_serial_port #(
  parameter int MS_CYCLES = serial_port_pkg::MS_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [serial_port_pkg::AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD,
  output logic TXD,
  input wire logic CTS,
  output logic RTS
);
  import serial_port_pkg::*;

  typedef struct packed {
    cfg_t cfg;
    term_t term;
    logic [13:0] sil_ms;
    logic [13:0] cts_ms;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] rxd_s;
    logic [1:0] cts_s;
    logic [16:0] ms_cnt;
    logic [14:0] bcnt;
    rx_state_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    tx_state_t tx_st;
    logic [3:0] tx_tick;
    logic [3:0] tx_bit;
    logic [11:0] tx_sh;
    logic [13:0] tx_wait;
    logic [7:0] tx_char;
    logic txd;
    logic rts;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [10:0] count;
    logic echo_pend;
    logic [7:0] echo_char;
    logic [13:0] sil_cnt;
    logic rx_open;
    logic rx_end;
    logic par_err;
    logic frm_err;
    logic tx_abort;
    logic overrun;
  } state_t;

  state_t s;
  state_t n;
  logic [7:0] mem [DEPTH];
  logic rxd;
  logic cts;
  logic ms_tick;
  logic btick;
  logic hs_eff;
  logic [3:0] nd;
  logic pe;
  logic [3:0] nbits;
  logic [7:0] cmask;
  logic [13:0] sil_min;
  logic [13:0] sil_eff;
  logic access;
  logic stall;
  logic push;
  logic pop;
  logic [7:0] pch;
  logic rx_done;
  logic [7:0] rx_ch;
  logic hit1;
  logic hit2;
  logic keep;
  logic [11:0] frame;
  logic [13:0] wval;
  logic clr;
  term_t wterm;
  status_t sts;

  function automatic logic par_bit(par_t p, logic [7:0] d);
    return (p == PAR_ODD) ? ~^d : ^d;
  endfunction

  function automatic logic slot_hit(slot_t sl, logic [7:0] pv, logic [7:0] c);
    logic [7:0] want;
    want = (sl.sel == END_CR) ? CHAR_CR : (sl.sel == END_LF) ? CHAR_LF : pv;
    return sl.en && (c == want);
  endfunction

  always_comb
  begin
    n = s;
    rxd = s.rxd_s[1];
    cts = s.cts_s[1];
    n.rxd_s = {s.rxd_s[0], RXD};
    n.cts_s = {s.cts_s[0], CTS};
    // write one clears status flags first, so an event in the same cycle wins
    if (PSEL && PENABLE && !s.pready && PWRITE && PADDR == A_STATUS)
    begin
      n.rx_end = s.rx_end & ~PWDATA[0];
      n.par_err = s.par_err & ~PWDATA[1];
      n.frm_err = s.frm_err & ~PWDATA[2];
      n.tx_abort = s.tx_abort & ~PWDATA[3];
      n.overrun = s.overrun & ~PWDATA[STS_W1C_W];
    end
    // ----------------------------------------------------------------
    // frame format and timebases
    // ----------------------------------------------------------------
    hs_eff = s.cfg.hs && !s.cfg.rs485;
    nd = s.cfg.data8 ? NDATA8 : NDATA7;
    pe = (s.cfg.parity == PAR_EVEN) || (s.cfg.parity == PAR_ODD);
    nbits = 4'd1 + nd + {3'd0, pe} + (s.cfg.stop2 ? 4'd2 : 4'd1);
    cmask = s.cfg.data8 ? MASK8 : MASK7;
    ms_tick = (s.ms_cnt >= 17'(MS_CYCLES - 1));
    n.ms_cnt = ms_tick ? 17'd0 : s.ms_cnt + 17'd1;
    btick = (s.bcnt >= DIV_TAB[s.cfg.baud] - 15'd1);
    n.bcnt = btick ? 15'd0 : s.bcnt + 15'd1;
    sil_min = (nbits >= 4'(LONG_CHAR_BITS)) ? 14'(MIN15_TAB[s.cfg.baud])
                                            : 14'(MIN12_TAB[s.cfg.baud]);
    sil_eff = (s.sil_ms > sil_min) ? s.sil_ms : sil_min;
    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    rx_done = 1'b0;
    rx_ch = s.rx_sh & cmask;
    case (s.rx_st)
      RX_IDLE:
      begin
        n.rx_tick = 4'd0;
        if (!rxd)
          n.rx_st = RX_START;
      end
      RX_START:
      begin
        if (btick)
        begin
          n.rx_tick = s.rx_tick + 4'd1;
          if (s.rx_tick == OVS_MID)
          begin
            n.rx_tick = 4'd0;
            n.rx_bit = 4'd0;
            n.rx_sh = 8'h00;
            n.rx_st = rxd ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (btick)
        begin
          n.rx_tick = s.rx_tick + 4'd1;
          if (s.rx_tick == OVS_LAST)
          begin
            n.rx_bit = s.rx_bit + 4'd1;
            if (s.rx_bit < nd)
              n.rx_sh[s.rx_bit[2:0]] = rxd;
            else if (rxd != par_bit(s.cfg.parity, s.rx_sh & cmask))
              n.par_err = 1'b1;
            if (s.rx_bit == nd + {3'd0, pe} - 4'd1)
              n.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (btick)
        begin
          n.rx_tick = s.rx_tick + 4'd1;
          if (s.rx_tick == OVS_LAST)
          begin
            if (!rxd)
              n.frm_err = 1'b1;
            rx_done = 1'b1;
            n.rx_st = RX_IDLE;
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    // ----------------------------------------------------------------
    // end of reception
    // ----------------------------------------------------------------
    hit1 = slot_hit(s.term.s1, s.term.prog1 & cmask, rx_ch);
    hit2 = !hit1 && slot_hit(s.term.s2, s.term.prog2 & cmask, rx_ch);
    keep = !((hit1 && !s.term.s1.incl) || (hit2 && !s.term.s2.incl));
    if (rx_done)
    begin
      n.sil_cnt = 14'd0;
      n.rx_open = 1'b1;
      if (hit1 || hit2)
      begin
        n.rx_end = 1'b1;
        n.rx_open = 1'b0;
      end
    end
    else if (ms_tick && s.rx_open && s.term.sil_en)
    begin
      n.sil_cnt = s.sil_cnt + 14'd1;
      if (s.sil_cnt + 14'd1 >= sil_eff)
      begin
        n.rx_end = 1'b1;
        n.rx_open = 1'b0;
      end
    end
    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    frame = 12'hfff;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < nd)
        frame[i + 1] = s.tx_char[i];
    end
    if (pe)
      frame[nd + 4'd1] = par_bit(s.cfg.parity, s.tx_char);
    case (s.tx_st)
      TX_IDLE: n.tx_wait = 14'd0;
      TX_WAIT:
      begin
        if (!hs_eff || cts)
        begin
          n.tx_sh = frame;
          n.tx_tick = 4'd0;
          n.tx_bit = 4'd0;
          n.echo_pend = 1'b1;
          n.echo_char = s.tx_char;
          n.tx_st = TX_SEND;
        end
        else if (s.cts_ms != 14'd0 && s.tx_wait >= s.cts_ms)
        begin
          n.tx_abort = 1'b1;
          n.tx_st = TX_IDLE;
        end
        else if (ms_tick)
          n.tx_wait = s.tx_wait + 14'd1;
      end
      TX_SEND:
      begin
        if (btick)
        begin
          n.tx_tick = s.tx_tick + 4'd1;
          if (s.tx_tick == OVS_LAST)
          begin
            n.tx_sh = {1'b1, s.tx_sh[11:1]};
            n.tx_bit = s.tx_bit + 4'd1;
            if (s.tx_bit == nbits - 4'd1)
              n.tx_st = TX_IDLE;
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    access = PSEL && PENABLE && !s.pready;
    stall = PWRITE && (PADDR == A_TXDATA) && (s.tx_st != TX_IDLE);
    n.pready = access && !stall;
    n.pslverr = 1'b0;
    n.prdata = 32'h0;
    pop = 1'b0;
    clr = 1'b0;
    wval = PWDATA[13:0];
    wterm = term_t'(PWDATA[$bits(term_t)-1:0]);
    sts = '0;
    sts.count = s.count;
    sts.overrun = s.overrun;
    sts.tx_busy = (s.tx_st != TX_IDLE);
    sts.tx_abort = s.tx_abort;
    sts.frm_err = s.frm_err;
    sts.par_err = s.par_err;
    sts.rx_end = s.rx_end;
    if (access && !stall)
    begin
      case (PADDR)
        A_CFG:
        begin
          n.prdata = 32'(s.cfg);
          if (PWRITE)
            n.cfg = cfg_t'(PWDATA[$bits(cfg_t)-1:0]);
        end
        A_TERM:
        begin
          n.prdata = 32'(s.term);
          if (PWRITE)
          begin
            wterm.prog1 = wterm.prog1 & cmask;
            wterm.prog2 = wterm.prog2 & cmask;
            if (wterm.sil_en)
            begin
              wterm.s1.en = 1'b0;
              wterm.s2.en = 1'b0;
            end
            n.term = wterm;
          end
        end
        A_SIL:
        begin
          n.prdata = 32'(s.sil_ms);
          if (PWRITE)
            n.sil_ms = (PWDATA < 32'(SIL_MIN_MS)) ? 14'(SIL_MIN_MS) :
                       (PWDATA > 32'(SIL_MAX_MS)) ? 14'(SIL_MAX_MS) : wval;
        end
        A_CTSW:
        begin
          n.prdata = 32'(s.cts_ms);
          if (PWRITE)
            n.cts_ms = (PWDATA > 32'(CTS_MAX_MS)) ? 14'(CTS_MAX_MS) : wval;
        end
        A_TXDATA:
        begin
          n.prdata = 32'(s.tx_char);
          if (PWRITE)
          begin
            n.tx_char = PWDATA[7:0] & cmask;
            n.tx_st = TX_WAIT;
          end
        end
        A_RXDATA:
        begin
          if (!PWRITE && s.count != 11'd0)
          begin
            pop = 1'b1;
            n.prdata = {23'h0, 1'b1, mem[s.rd_ptr]};
          end
        end
        A_STATUS: n.prdata = 32'(sts);
        A_CTRL:
        begin
          if (PWRITE)
            clr = PWDATA[CTRL_CLR];
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // ----------------------------------------------------------------
    // receive buffer
    // ----------------------------------------------------------------
    push = 1'b0;
    pch = 8'h00;
    if (rx_done && keep)
    begin
      push = 1'b1;
      pch = rx_ch;
    end
    else if (s.echo_pend)
    begin
      push = 1'b1;
      pch = s.echo_char;
      n.echo_pend = n.echo_pend && (s.tx_st == TX_WAIT && n.tx_st == TX_SEND);
    end
    if (push)
      n.wr_ptr = s.wr_ptr + 10'd1;
    if (pop || (push && s.count == 11'(DEPTH)))
      n.rd_ptr = s.rd_ptr + 10'd1;
    if (push && s.count == 11'(DEPTH) && !pop)
      n.overrun = 1'b1;
    if (push && !pop && s.count != 11'(DEPTH))
      n.count = s.count + 11'd1;
    else if (pop && !push)
      n.count = s.count - 11'd1;
    if (clr)
    begin
      push = 1'b0;
      n.wr_ptr = '0;
      n.rd_ptr = '0;
      n.count = 11'd0;
      n.echo_pend = 1'b0;
      n.rx_open = 1'b0;
      n.rx_end = 1'b0;
      n.sil_cnt = 14'd0;
    end
    n.rts = hs_eff ? (n.count != 11'(DEPTH)) : 1'b1;
    n.txd = (n.tx_st == TX_SEND) ? n.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.sil_ms <= 14'(SIL_MIN_MS);
      s.rxd_s <= 2'b11;
      s.txd <= 1'b1;
      s.rts <= 1'b1;
    end
    else
      s <= n;
  end

  // entry cleared on read unless rewritten in the same cycle
  always_ff @(posedge CLK)
  begin
    if (pop && !(push && s.wr_ptr == s.rd_ptr))
      mem[s.rd_ptr] <= 8'h00;
    if (push)
      mem[s.wr_ptr] <= pch;
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign TXD = s.txd;
  assign RTS = s.rts;
endmodule

// >>> serial_port_pkg.sv
// Purpose: shared constants and types of the character-mode serial port
// Assumes: 100 MHz system clock, APB register access
// Notes: tables are built from the rate list at elaboration
package serial_port_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int OVS = 16;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int DEPTH = 1024;
  localparam int PTR_W = 10;
  localparam int SIL_MIN_MS = 1;
  localparam int SIL_MAX_MS = 10000;
  localparam int CTS_MAX_S = 10;
  localparam int CTS_MAX_MS = CTS_MAX_S * MS_PER_S;
  localparam int SIL_BITS_SHORT = 12;
  localparam int SIL_BITS_LONG = 15;
  localparam int LONG_CHAR_BITS = 10;
  localparam int RATES [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
  localparam logic [2:0] BAUD_9600 = 3'h5;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] MASK7 = 8'h7f;
  localparam logic [7:0] MASK8 = 8'hff;
  localparam logic [3:0] NDATA7 = 4'h7;
  localparam logic [3:0] NDATA8 = 4'h8;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_TERM = 8'h04;
  localparam logic [7:0] A_SIL = 8'h08;
  localparam logic [7:0] A_CTSW = 8'h0c;
  localparam logic [7:0] A_TXDATA = 8'h10;
  localparam logic [7:0] A_RXDATA = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_CTRL = 8'h1c;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} par_t;
  typedef enum logic [1:0] {END_CR = 2'b00, END_LF = 2'b01, END_PROG = 2'b10} end_sel_t;
  typedef struct packed {
    logic hs;
    logic rs485;
    par_t parity;
    logic stop2;
    logic data8;
    logic [2:0] baud;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{hs: 1'b0, rs485: 1'b0, parity: PAR_ODD, stop2: 1'b0,
                                 data8: 1'b1, baud: BAUD_9600};
  typedef struct packed {
    logic incl;
    end_sel_t sel;
    logic en;
  } slot_t;
  typedef struct packed {
    logic sil_en;
    logic [7:0] prog2;
    logic [7:0] prog1;
    slot_t s2;
    slot_t s1;
  } term_t;
  typedef struct packed {
    logic [10:0] count;
    logic [3:0] pad;
    logic overrun;
    logic tx_busy;
    logic tx_abort;
    logic frm_err;
    logic par_err;
    logic rx_end;
  } status_t;
  localparam int STS_W1C_W = 5;
  localparam int CTRL_CLR = 0;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                            RX_STOP = 2'b11} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10} tx_state_t;
  typedef logic [7:0][14:0] tab_t;
  function automatic tab_t mk_div();
    tab_t t;
    for (int i = 0; i < 8; i++)
    begin
      t[i] = 15'((CLK_HZ + RATES[i] * OVS / 2) / (RATES[i] * OVS));
    end
    return t;
  endfunction
  function automatic tab_t mk_min(int bits);
    tab_t t;
    for (int i = 0; i < 8; i++)
    begin
      t[i] = 15'((bits * MS_PER_S + RATES[i] - 1) / RATES[i]);
    end
    return t;
  endfunction
  localparam tab_t DIV_TAB = mk_div();
  localparam tab_t MIN12_TAB = mk_min(SIL_BITS_SHORT);
  localparam tab_t MIN15_TAB = mk_min(SIL_BITS_LONG);
endpackage

// >>> char_mode_serial_port_chk.sv
// Purpose: port-level checks of the character-mode serial port
// Assumes: an APB transfer completes when PSEL, PENABLE and PREADY are high together
// Notes: mode bits are mirrored from the CFG and TERM writes seen on the bus
`timescale 1ns/1ns
module char_mode_serial_port_chk #(
  parameter int MS_CYCLES = serial_port_pkg::MS_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [serial_port_pkg::AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic CTS,
  input wire logic RTS
);
  import serial_port_pkg::*;
  logic rd_ok;
  logic wr_ok;
  logic hs_eff;
  logic data8;
  logic term7;
  assign rd_ok = PSEL && PENABLE && PREADY && !PWRITE;
  assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
  // ----------------------------------------------------------------
  // mirror of the mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hs_eff <= 1'b0;
      data8 <= 1'b1;
      term7 <= 1'b0;
    end
    else
    begin
      if (wr_ok && PADDR == A_CFG)
      begin
        hs_eff <= PWDATA[8] & ~PWDATA[7];
        data8 <= PWDATA[3];
      end
      if (wr_ok && PADDR == A_TERM)
      begin
        term7 <= ~data8;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  property p_reset_idle;
    $rose(RST_B) |-> TXD && RTS && !PREADY;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
  property p_rx_word;
    rd_ok && PADDR == A_RXDATA |-> PRDATA[31:9] == 23'h0 && (PRDATA[8] || PRDATA == 32'h0);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("bad receive word");
  property p_term_excl;
    rd_ok && PADDR == A_TERM && PRDATA[24] |-> !PRDATA[0] && !PRDATA[4];
  endproperty
  a_term_excl: assert property (p_term_excl) else $error("silence and end chars both on");
  property p_term_7bit;
    rd_ok && PADDR == A_TERM && term7 |-> !PRDATA[15] && !PRDATA[23];
  endproperty
  a_term_7bit: assert property (p_term_7bit) else $error("end char above 127");
  property p_sil_range;
    rd_ok && PADDR == A_SIL |-> PRDATA >= 32'd1 && PRDATA <= 32'd10000;
  endproperty
  a_sil_range: assert property (p_sil_range) else $error("silence out of range");
  property p_ctsw_range;
    rd_ok && PADDR == A_CTSW |-> PRDATA <= 32'd10000;
  endproperty
  a_ctsw_range: assert property (p_ctsw_range) else $error("cts wait out of range");
  property p_count_max;
    rd_ok && PADDR == A_STATUS |-> PRDATA[20:10] <= 11'h400;
  endproperty
  a_count_max: assert property (p_count_max) else $error("buffer count too large");
  property p_rts_plain;
    !hs_eff && !$past(hs_eff) |-> RTS;
  endproperty
  a_rts_plain: assert property (p_rts_plain) else $error("rts low without handshake");
endmodule

// >>> far_serial_node.sv
// Purpose: remote serial node on the far side of the port
// Assumes: 38400 bit/s, 8 data bits, no parity, one stop bit
// Notes: its request to send feeds the port CTS unless held off
`timescale 1ns/1ns
module far_serial_node #(
  parameter int BIT_CYC = 2608
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts,
  input wire logic hold_off,
  output logic rxd,
  output logic cts
);
  logic [7:0] got;
  logic [7:0] last_rx;
  int n_rx;
  int n_bad;
  // ----------------------------------------------------------------
  // flow control and sender
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cts <= ~hold_off;
  end
  task automatic send_char(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    while (rts !== 1'b1)
    begin
      @(posedge clk);
    end
    for (int i = 0; i < 10; i++)
    begin
      rxd <= frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // ----------------------------------------------------------------
  // receiver, samples mid-bit
  // ----------------------------------------------------------------
  initial
  begin
    rxd = 1'b1;
    n_rx = 0;
    n_bad = 0;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        got[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (txd !== 1'b1)
      begin
        n_bad++;
      end
      last_rx = got;
      n_rx++;
    end
  end
endmodule

// >>> char_mode_serial_port_bench.sv
// Purpose: self-checking bench of the character-mode serial port
// Assumes: millisecond tick shortened to 50 clocks, traffic at 38400 bit/s
// Notes: registers reached through APB tasks, far node model on the line
`timescale 1ns/1ns
module char_mode_serial_port_bench;
  import serial_port_pkg::*;
  localparam int MS_SIM = 50;
  logic CLK;
  logic RST_B;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  logic [AW-1:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic RXD;
  logic TXD;
  logic CTS;
  logic RTS;
  logic hold_off;
  logic [31:0] rdata;
  logic rerr;
  int bad_count;
  int n_compared;
  char_mode_serial_port #(.MS_CYCLES(MS_SIM)) i_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .CTS(CTS), .RTS(RTS));
  far_serial_node i_far (.clk(CLK), .txd(TXD), .rts(RTS), .hold_off(hold_off), .rxd(RXD),
    .cts(CTS));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 40000)
    begin
      @(posedge CLK);
      n++;
    end
    check("bus answer", 32'h1, {31'h0, PREADY});
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever
    begin
      #5 CLK = ~CLK;
    end
  end
  initial
  begin
    repeat (100000) @(posedge CLK);
    $display("[FAIL] watchdog expected end seen hang");
    bad_count++;
    complete_run();
  end
  initial
  begin
    bad_count = 0;
    n_compared = 0;
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    hold_off = 1'b0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd_chk(A_CFG, 32'h0000_004d);
    rd_chk(A_TERM, 32'h0);
    rd_chk(A_SIL, 32'h1);
    rd_chk(A_CTSW, 32'h0);
    rd_chk(A_STATUS, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    // limits and exclusive termination
    bus(1'b1, A_SIL, 32'h0);
    rd_chk(A_SIL, 32'h1);
    bus(1'b1, A_SIL, 32'h4e20);
    rd_chk(A_SIL, 32'h2710);
    bus(1'b1, A_CTSW, 32'h4e20);
    rd_chk(A_CTSW, 32'h2710);
    bus(1'b1, A_TERM, 32'h0100_0011);
    rd_chk(A_TERM, 32'h0100_0000);
    bus(1'b1, A_TERM, 32'h0000_0001);
    rd_chk(A_TERM, 32'h0000_0001);
    bus(1'b1, A_CFG, 32'h0000_0007);
    bus(1'b1, A_TERM, 32'h00ff_ff00);
    rd_chk(A_TERM, 32'h007f_7f00);
    // full duplex, cts low ignored without handshake
    hold_off <= 1'b1;
    bus(1'b1, A_CFG, 32'h0000_000f);
    bus(1'b1, A_CTSW, 32'h1);
    bus(1'b1, A_TERM, 32'h0000_0009);
    bus(1'b1, A_TXDATA, 32'h55);
    rd_chk(A_RXDATA, 32'h155);
    i_far.send_char(CHAR_CR);
    rd_chk(A_STATUS, 32'h0000_0401);
    check("far char", 32'h55, {24'h0, i_far.last_rx});
    check("far stop", 32'h0, 32'(i_far.n_bad));
    bus(1'b1, A_CTRL, 32'h1);
    rd_chk(A_STATUS, 32'h0);
    rd_chk(A_RXDATA, 32'h0);
    bus(1'b1, A_TERM, 32'h0000_0030);
    i_far.send_char(CHAR_LF);
    rd_chk(A_STATUS, 32'h0000_0001);
    // handshake: abort after the wait limit, then unbounded wait
    bus(1'b1, A_STATUS, 32'h1);
    bus(1'b1, A_CFG, 32'h0000_010f);
    check("rts", 32'h1, {31'h0, RTS});
    bus(1'b1, A_TXDATA, 32'h33);
    repeat (3 * MS_SIM) @(posedge CLK);
    rd_chk(A_STATUS, 32'h0000_0008);
    check("far count", 32'h1, 32'(i_far.n_rx));
    bus(1'b1, A_STATUS, 32'h8);
    bus(1'b1, A_CTSW, 32'h0);
    bus(1'b1, A_TXDATA, 32'h44);
    repeat (3 * MS_SIM) @(posedge CLK);
    rd_chk(A_STATUS, 32'h0000_0010);
    // silence end while the held character goes out, full duplex
    bus(1'b1, A_TERM, 32'h0100_0000);
    bus(1'b1, A_SIL, 32'h64);
    hold_off <= 1'b0;
    i_far.send_char(8'h41);
    bus(1'b0, A_STATUS, 32'h0);
    check("silence early", 32'h0000_0800, rdata & 32'hffff_ffef);
    repeat (100 * MS_SIM) @(posedge CLK);
    for (int i = 0; i < 10000 && rdata[4] !== 1'b0; i++)
    begin
      bus(1'b0, A_STATUS, 32'h0);
    end
    check("far char", 32'h44, {24'h0, i_far.last_rx});
    rd_chk(A_RXDATA, 32'h144);
    rd_chk(A_STATUS, 32'h0000_0401);
    rd_chk(A_RXDATA, 32'h141);
    complete_run();
  end
endmodule
bind char_mode_serial_port char_mode_serial_port_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD),
  .TXD(TXD), .CTS(CTS), .RTS(RTS));
